// File: inc/wrb_pkg.sv
// package: constants for the warm restart and boot history block
package wrb_pkg;
	localparam logic [31:0] SYNC_WORD      = 32'hAA995566;
	localparam logic [31:0] HDR_WR_START   = 32'h30020001;
	localparam logic [31:0] HDR_WR_CMD     = 32'h30008001;
	localparam logic [31:0] CMD_NULL       = 32'h00000000;
	localparam logic [31:0] CMD_RESTART    = 32'h0000000F;
	localparam logic [3:0]  CMD_LOW_MASK   = 4'hF;
	localparam int          ADDR_W         = 26;
	localparam int          SPI_ADDR_W     = 24;
	localparam logic [25:0] ADDR_DOWN_DFLT = 26'h3FFFFFF;
	localparam logic [25:0] ADDR_UP_DFLT   = 26'h0000000;
	localparam logic [1:0]  RS_FALLBACK    = 2'h0;
	// start register layout: revision select on top, address below
	localparam int          START_RS_LSB   = 26;
	localparam logic [27:0] START_RESET    = 28'h0000000;
	// boot history entry bit positions
	localparam int          HB_BGCHK = 7;
	localparam int          HB_WRAP  = 6;
	localparam int          HB_CHK   = 5;
	localparam int          HB_ID    = 4;
	localparam int          HB_WDOG  = 3;
	localparam int          HB_RST   = 2;
	localparam int          HB_FB    = 1;
	localparam int          HB_VALID = 0;
	localparam logic [15:0] HIST_RESET = 16'h0000;
	// clear time in cycles
	localparam int          CLEAR_CYCLES = 16;
	typedef enum logic [1:0] {
		MODE_SERIAL_OTHER,
		MODE_PFLASH_UP,
		MODE_PFLASH_DOWN,
		MODE_SPI
	} wrb_mode_type;
endpackage

// File: verilog/wrb_cmd_parse.sv
// module: parser for configuration words from port or bitstream
`timescale 1ns/1ps
module wrb_cmd_parse (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_q_b,
	// word stream
	input  wire logic        word_valid,
	input  wire logic [31:0] word_data,
	input  wire logic        desync,
	// decoded events
	output logic             start_wr,
	output logic [31:0]      start_data,
	output logic             restart_seen
);
	typedef enum logic [1:0] {P_IDLE, P_SYNCED, P_START, P_CMD} wrb_pstate_type;
	wrb_pstate_type st_reg;

	// header/payload tracking; one word per header
	always_ff @(posedge clk or negedge rst_q_b) begin
		if (!rst_q_b) begin
			st_reg       <= P_IDLE;
			start_wr     <= 1'b0;
			start_data   <= 32'h00000000;
			restart_seen <= 1'b0;
		end else begin
			start_wr     <= 1'b0;
			restart_seen <= 1'b0;
			if (desync) begin
				st_reg <= P_IDLE;
			end else if (word_valid) begin
				case (st_reg)
					P_IDLE: begin
						if (word_data == wrb_pkg::SYNC_WORD) st_reg <= P_SYNCED;
					end
					P_SYNCED: begin
						if (word_data == wrb_pkg::HDR_WR_START) st_reg <= P_START;
						else if (word_data == wrb_pkg::HDR_WR_CMD) st_reg <= P_CMD;
					end
					P_START: begin
						start_wr   <= 1'b1;
						start_data <= word_data;
						st_reg     <= P_SYNCED;
					end
					P_CMD: begin
						// patched null command with low nibble all ones
						restart_seen <= (word_data == wrb_pkg::CMD_RESTART);
						st_reg       <= P_SYNCED;
					end
					default: st_reg <= P_IDLE;
				endcase
			end
		end
	end
endmodule

// File: verilog/wrb_top.sv
// module: warm restart control, flash address drive and boot history
//
// Contract
// - restart resets all but reboot logic
// - load from stored start, else mode default
// - accept restart from port or bitstream
// - restart code is null with low nibble set
// - pull init and done low, clear, release
// - spi mode sends 24-bit start serially
// - select pins follow stored value in all modes
// - actively drive select pins during restart load
// - release flash pins after configuration
// - failed restarted image falls back to zero
// - history is two-entry shifting queue
// - each entry carries a valid flag
// - clean first load: newest valid only
// - restart success: newest restart plus valid
// - check failure then fallback recorded in both
// - ignore restart in fallback, still record it
// - id, check, watchdog, wrap errors cause fallback
// - on error reset and drive select zero; an error in a fallback load halts instead, with no reset
`timescale 1ns/1ps
module wrb_top #(
	parameter int ADDR_W     = wrb_pkg::ADDR_W,
	parameter int SPI_ADDR_W = wrb_pkg::SPI_ADDR_W
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// configuration mode straps
	input  wire logic [1:0]        config_mode,
	// internal configuration port words
	input  wire logic              icp_valid,
	input  wire logic [31:0]       icp_data,
	input  wire logic              icp_desync,
	// bitstream words during a load
	input  wire logic              bs_valid,
	input  wire logic [31:0]       bs_data,
	// load outcome from the loader
	input  wire logic              load_done,
	input  wire logic              err_bgchk,
	input  wire logic              err_wrap,
	input  wire logic              err_chk,
	input  wire logic              err_id,
	input  wire logic              err_wdog,
	// pins toward flash and system
	output logic                   init_status,
	output logic                   done_pin,
	output logic                   config_reset,
	output logic                   mem_clear,
	output logic                   load_start,
	output logic [1:0]             revision_select_pins,
	output logic                   revision_select_oe,
	output logic [ADDR_W-1:0]      flash_addr,
	output logic                   flash_addr_oe,
	output logic                   spi_mosi,
	output logic                   spi_cs_b,
	output logic                   config_halted,
	// boot history read port
	output logic [15:0]            boot_history
);
	typedef enum logic [2:0] {S_IDLE, S_RESET, S_CLEAR, S_SPI, S_LOAD, S_USER, S_HALT} wrb_state_type;

	logic          rst_m_reg;
	logic          rst_q_reg;
	wrb_state_type st_reg;
	logic [27:0]   warm_boot_start_reg;
	logic          fallback_reg;
	logic          restart_load_reg;
	logic          restart_in_load_reg;
	logic [7:0]    clr_cnt_reg;
	logic [4:0]    spi_cnt_reg;
	logic [SPI_ADDR_W-1:0] spi_sh_reg;
	logic          icp_start_wr;
	logic [31:0]   icp_start_data;
	logic          icp_restart;
	logic          bs_start_wr;
	logic [31:0]   bs_start_data;
	logic          bs_restart;
	logic          any_err;
	logic [7:0]    entry_next;
	logic          clr_last;
	logic          spi_last;
	logic          load_fail;
	logic          load_ok;
	logic          bs_go;
	logic          icp_go;
	wrb_pkg::wrb_mode_type mode;

	assign mode    = wrb_pkg::wrb_mode_type'(config_mode);
	assign any_err = err_wrap | err_chk | err_id | err_wdog;

	// default start address per mode for first and fallback loads
	function automatic logic [ADDR_W-1:0] addr_default(input wrb_pkg::wrb_mode_type m);
		addr_default = (m == wrb_pkg::MODE_PFLASH_DOWN) ? ADDR_W'(wrb_pkg::ADDR_DOWN_DFLT)
			: ADDR_W'(wrb_pkg::ADDR_UP_DFLT);
	endfunction

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_m_reg <= 1'b0;
			rst_q_reg <= 1'b0;
		end else begin
			rst_m_reg <= 1'b1;
			rst_q_reg <= rst_m_reg;
		end
	end

	// two parsers: user port and bitstream being loaded
	wrb_cmd_parse u_icp_parse (
		.clk          (clk),
		.rst_q_b      (rst_q_reg),
		.word_valid   (icp_valid),
		.word_data    (icp_data),
		.desync       (icp_desync),
		.start_wr     (icp_start_wr),
		.start_data   (icp_start_data),
		.restart_seen (icp_restart)
	);

	wrb_cmd_parse u_bs_parse (
		.clk          (clk),
		.rst_q_b      (rst_q_reg),
		.word_valid   (bs_valid & (st_reg == S_LOAD)),
		.word_data    (bs_data),
		.desync       (st_reg != S_LOAD),
		.start_wr     (bs_start_wr),
		.start_data   (bs_start_data),
		.restart_seen (bs_restart)
	);

	// stored start survives restarts; only the block reset clears it
	always_ff @(posedge clk or negedge rst_q_reg) begin
		if (!rst_q_reg) begin
			warm_boot_start_reg <= wrb_pkg::START_RESET;
		end else if (icp_start_wr && st_reg == S_USER) begin
			warm_boot_start_reg <= icp_start_data[27:0];
		end else if (bs_start_wr && !fallback_reg) begin
			warm_boot_start_reg <= bs_start_data[27:0];
		end
	end

	// entry for the load that just finished
	always_comb begin
		entry_next                  = 8'h00;
		entry_next[wrb_pkg::HB_BGCHK] = err_bgchk;
		entry_next[wrb_pkg::HB_WRAP]  = err_wrap;
		entry_next[wrb_pkg::HB_CHK]   = err_chk;
		entry_next[wrb_pkg::HB_ID]    = err_id;
		entry_next[wrb_pkg::HB_WDOG]  = err_wdog;
		// a restart word seen in the last cycle of the load still counts
		entry_next[wrb_pkg::HB_RST]   = restart_load_reg | restart_in_load_reg | bs_restart;
		entry_next[wrb_pkg::HB_FB]    = fallback_reg;
		entry_next[wrb_pkg::HB_VALID] = 1'b1;
	end

	// history: newest in low byte, previous newest shifts up
	always_ff @(posedge clk or negedge rst_q_reg) begin
		if (!rst_q_reg) begin
			boot_history <= wrb_pkg::HIST_RESET;
		end else if (st_reg == S_LOAD && (load_done || any_err)) begin
			boot_history <= {boot_history[7:0], entry_next};
		end
	end

	// restart flag seen in the image itself, kept even in fallback
	always_ff @(posedge clk or negedge rst_q_reg) begin
		if (!rst_q_reg) begin
			restart_in_load_reg <= 1'b0;
		end else if (st_reg == S_CLEAR) begin
			restart_in_load_reg <= 1'b0;
		end else if (st_reg == S_LOAD && bs_restart) begin
			restart_in_load_reg <= 1'b1;
		end
	end

	// decoded steps of the sequence, shared by the blocks below
	assign clr_last  = (st_reg == S_CLEAR) && (clr_cnt_reg == 8'(wrb_pkg::CLEAR_CYCLES));
	assign spi_last  = (st_reg == S_SPI) && (spi_cnt_reg == 5'(SPI_ADDR_W - 1));
	assign load_fail = (st_reg == S_LOAD) && any_err;
	// restart word inside a fallback image is not acted on
	assign bs_go     = (st_reg == S_LOAD) && !any_err && bs_restart && !fallback_reg;
	assign icp_go    = (st_reg == S_USER) && icp_restart;
	assign load_ok   = (st_reg == S_LOAD) && !any_err && !bs_go && load_done;

	// main sequence: reset, clear, address, load, user
	always_ff @(posedge clk or negedge rst_q_reg) begin
		if (!rst_q_reg) begin
			st_reg <= S_CLEAR;
		end else begin
			case (st_reg)
				S_IDLE: st_reg <= S_CLEAR;
				S_RESET: st_reg <= S_CLEAR;
				S_CLEAR: begin
					if (clr_last) begin
						st_reg <= (mode == wrb_pkg::MODE_SPI) ? S_SPI : S_LOAD;
					end
				end
				S_SPI: begin
					if (spi_last) begin
						st_reg <= S_LOAD;
					end
				end
				S_LOAD: begin
					if (load_fail) begin
						// second failure stops configuration
						st_reg <= fallback_reg ? S_HALT : S_RESET;
					end else if (bs_go) begin
						st_reg <= S_RESET;
					end else if (load_ok) begin
						st_reg <= S_USER;
					end
				end
				S_USER: begin
					if (icp_go) begin
						st_reg <= S_RESET;
					end
				end
				S_HALT: st_reg <= S_HALT;
				default: st_reg <= S_RESET;
			endcase
		end
	end

	// fallback and warm-restart flags for the next load
	always_ff @(posedge clk or negedge rst_q_reg) begin
		if (!rst_q_reg) begin
			fallback_reg     <= 1'b0;
			restart_load_reg <= 1'b0;
		end else if (load_fail && !fallback_reg) begin
			fallback_reg     <= 1'b1;
			restart_load_reg <= 1'b0;
		end else if (bs_go) begin
			restart_load_reg <= 1'b1;
		end else if (icp_go) begin
			// a port restart re-arms normal loading after a fallback
			fallback_reg     <= 1'b0;
			restart_load_reg <= 1'b1;
		end
	end

	// clear phase: full count of cycles with memory clear high
	always_ff @(posedge clk or negedge rst_q_reg) begin
		if (!rst_q_reg) begin
			clr_cnt_reg <= 8'h00;
			mem_clear   <= 1'b0;
		end else if (st_reg != S_CLEAR) begin
			clr_cnt_reg <= 8'h00;
			mem_clear   <= 1'b0;
		end else if (clr_last) begin
			mem_clear   <= 1'b0;
		end else begin
			clr_cnt_reg <= clr_cnt_reg + 8'h01;
			mem_clear   <= 1'b1;
		end
	end

	// status pins: low through reset and clear, init high for loading
	always_ff @(posedge clk or negedge rst_q_reg) begin
		if (!rst_q_reg) begin
			init_status   <= 1'b0;
			done_pin      <= 1'b0;
			config_halted <= 1'b0;
		end else if (st_reg == S_RESET || st_reg == S_HALT) begin
			init_status <= 1'b0;
			done_pin    <= 1'b0;
		end else if (clr_last) begin
			init_status <= 1'b1;
		end else if (load_fail && fallback_reg) begin
			config_halted <= 1'b1;
		end else if (load_ok) begin
			done_pin <= 1'b1;
		end
	end

	// one-cycle pulses toward the loader
	always_ff @(posedge clk or negedge rst_q_reg) begin
		if (!rst_q_reg) begin
			config_reset <= 1'b0;
			load_start   <= 1'b0;
		end else begin
			// same effect as external reconfigure pulse
			config_reset <= (st_reg == S_RESET);
			load_start   <= (clr_last && mode != wrb_pkg::MODE_SPI) || spi_last;
		end
	end

	// select and address for the coming load, zero select on fallback
	always_ff @(posedge clk or negedge rst_q_reg) begin
		if (!rst_q_reg) begin
			revision_select_pins <= 2'h0;
			revision_select_oe   <= 1'b0;
			flash_addr           <= '0;
			flash_addr_oe        <= 1'b0;
		end else if (clr_last) begin
			if (fallback_reg) begin
				revision_select_pins <= wrb_pkg::RS_FALLBACK;
				revision_select_oe   <= 1'b1;
				flash_addr           <= addr_default(mode);
			end else if (restart_load_reg) begin
				revision_select_pins <= warm_boot_start_reg[wrb_pkg::START_RS_LSB +: 2];
				revision_select_oe   <= 1'b1;
				flash_addr           <= warm_boot_start_reg[ADDR_W-1:0];
			end else begin
				// first load leaves the pins to their resistors
				revision_select_oe   <= 1'b0;
				flash_addr           <= addr_default(mode);
			end
			flash_addr_oe <= (mode == wrb_pkg::MODE_PFLASH_UP) ||
				(mode == wrb_pkg::MODE_PFLASH_DOWN);
		end else if (load_ok) begin
			// flash pins become user io after configuration
			flash_addr_oe      <= 1'b0;
			revision_select_oe <= 1'b0;
		end
	end

	// start field shifted out msb first, one bit per cycle
	always_ff @(posedge clk or negedge rst_q_reg) begin
		if (!rst_q_reg) begin
			spi_cnt_reg <= 5'h00;
			spi_sh_reg  <= '0;
			spi_mosi    <= 1'b0;
		end else if (clr_last) begin
			// first and fallback loads start at address zero
			spi_sh_reg  <= (restart_load_reg && !fallback_reg) ?
				warm_boot_start_reg[SPI_ADDR_W-1:0] : '0;
			spi_cnt_reg <= 5'h00;
		end else if (st_reg == S_SPI) begin
			spi_mosi    <= spi_sh_reg[SPI_ADDR_W-1];
			spi_sh_reg  <= {spi_sh_reg[SPI_ADDR_W-2:0], 1'b0};
			spi_cnt_reg <= spi_cnt_reg + 5'h01;
		end
	end

	// flash select held through the load, dropped on every outcome
	always_ff @(posedge clk or negedge rst_q_reg) begin
		if (!rst_q_reg) begin
			spi_cs_b <= 1'b1;
		end else if (clr_last && mode == wrb_pkg::MODE_SPI) begin
			spi_cs_b <= 1'b0;
		end else if (load_fail || bs_go || load_ok) begin
			// a high gap lets the flash see each address afresh
			spi_cs_b <= 1'b1;
		end
	end
endmodule

// File: tb/wrb_top_asserts.sv
// checker: port-level timing of restart, clear and boot history
`timescale 1ns/1ps
module wrb_top_asserts (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_b,
	// port words and load outcome
	input wire logic        icp_valid,
	input wire logic [31:0] icp_data,
	input wire logic        load_done,
	input wire logic        err_bgchk,
	input wire logic        err_wrap,
	input wire logic        err_chk,
	input wire logic        err_id,
	input wire logic        err_wdog,
	// outputs watched
	input wire logic        init_status,
	input wire logic        done_pin,
	input wire logic        config_reset,
	input wire logic        mem_clear,
	input wire logic        revision_select_oe,
	input wire logic        flash_addr_oe,
	input wire logic        config_halted,
	input wire logic [15:0] boot_history
);
	logic [7:0] clr_cnt;
	logic       ev;
	logic       fb_err;
	// bgchk is recorded but never starts a fallback
	assign ev = load_done | err_bgchk | err_wrap | err_chk | err_id | err_wdog;
	assign fb_err = err_wrap | err_chk | err_id | err_wdog;
	// length of the current clear phase
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			clr_cnt <= 8'h00;
		else
			clr_cnt <= mem_clear ? clr_cnt + 8'h01 : 8'h00;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence cmd_hdr_s;
		icp_valid && icp_data == wrb_pkg::HDR_WR_CMD && done_pin;
	endsequence
	sequence cmd_code_s;
		icp_valid && icp_data == wrb_pkg::CMD_RESTART;
	endsequence
	sequence load_err_s;
		fb_err && init_status && !done_pin && !config_halted;
	endsequence
	a_restart_answer: assert property (cmd_hdr_s ##1 cmd_code_s |-> ##[1:3] config_reset)
		else $error("port restart gave no reset pulse");
	a_reset_pins_low: assert property (config_reset |-> !init_status && !done_pin)
		else $error("init or done high at restart");
	a_clear_count: assert property ($fell(mem_clear) |-> clr_cnt == wrb_pkg::CLEAR_CYCLES)
		else $error("clear phase of wrong length");
	a_clear_init_low: assert property (mem_clear |-> !init_status)
		else $error("init high during clear");
	a_select_driven: assert property (config_reset |-> ##[1:30] revision_select_oe)
		else $error("select pins not driven after reset");
	a_error_fallback: assert property (load_err_s |-> ##[1:4] (config_reset || config_halted))
		else $error("load error without fallback");
	a_hist_cause: assert property (!$stable(boot_history) |-> $past(ev) || $past(ev, 2))
		else $error("history moved without a load outcome");
	a_hist_shift: assert property (!$stable(boot_history) |-> boot_history[15:8] == $past(boot_history[7:0]))
		else $error("older entry is not the previous newest");
	a_hist_valid: assert property (!$stable(boot_history) |-> boot_history[wrb_pkg::HB_VALID])
		else $error("new entry without valid");
	a_addr_release: assert property (done_pin |-> !flash_addr_oe)
		else $error("flash address still driven after done");
endmodule
bind wrb_top wrb_top_asserts u_chk (.clk, .rst_b, .icp_valid, .icp_data, .load_done, .err_bgchk, .err_wrap,
	.err_chk, .err_id, .err_wdog, .init_status, .done_pin, .config_reset, .mem_clear, .revision_select_oe,
	.flash_addr_oe, .config_halted, .boot_history);

// File: tb/wrb_flash_model.sv
// model: flash image source and loader outcome
`timescale 1ns/1ps
module wrb_flash_model (
	// clock and load trigger
	input  wire logic        clk,
	input  wire logic        load_start,
	// scenario controls
	input  wire logic [4:0]  err_sel,
	input  wire logic        emb,
	// serial flash line from the block
	input  wire logic        spi_mosi,
	input  wire logic        spi_cs_b,
	// toward the block
	output logic             bs_valid,
	output logic [31:0]      bs_data,
	output logic             load_done,
	output logic [4:0]       err_v,
	// start field seen on the serial line
	output logic [23:0]      spi_addr
);
	// image words: a null command patched into the restart code
	logic [31:0] img [3];
	logic [4:0]  n_bit;
	// bits follow one cycle after select falls; the count stops after 24
	always @(posedge clk) begin
		if (spi_cs_b !== 1'b0) begin
			n_bit <= 5'h00;
		end else if (n_bit != 5'h19) begin
			n_bit <= n_bit + 5'h01;
			if (n_bit != 5'h00)
				spi_addr <= {spi_addr[22:0], spi_mosi};
		end
	end
	initial begin
		img = '{wrb_pkg::SYNC_WORD, wrb_pkg::HDR_WR_CMD, wrb_pkg::CMD_NULL | 32'(wrb_pkg::CMD_LOW_MASK)};
		bs_valid = 1'b0;
		bs_data = 32'h00000000;
		load_done = 1'b0;
		err_v = 5'h00;
		forever begin
			@(negedge clk);
			if (load_start === 1'b1) begin
				repeat (4) @(negedge clk);
				for (int i = 0; i < 3; i++) begin
					bs_valid = emb;
					bs_data = img[i];
					@(negedge clk);
				end
				// released data line shows the inverse, not the last word
				bs_valid = 1'b0;
				bs_data = ~bs_data;
				if (err_sel === 5'h00)
					load_done = 1'b1;
				else
					err_v = err_sel;
				@(negedge clk);
				load_done = 1'b0;
				err_v = 5'h00;
			end
		end
	end
endmodule

// File: tb/test_warm_reboot_boot_history.sv
// testbench: warm restart, fallback and boot history
`timescale 1ns/1ps
module test_warm_reboot_boot_history;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [1:0]  config_mode = 2'h1;
	logic        icp_valid = 1'b0;
	logic [31:0] icp_data = 32'h00000000;
	logic [4:0]  err_sel = 5'h00;
	logic        emb = 1'b0;
	logic        bs_valid, load_done, init_status, done_pin, config_reset, load_start;
	logic        revision_select_oe, flash_addr_oe;
	logic        spi_mosi, spi_cs_b, config_halted;
	logic [23:0] spi_addr;
	logic [31:0] bs_data;
	logic [4:0]  err_v;
	logic [1:0]  revision_select_pins;
	logic [25:0] flash_addr;
	logic [15:0] boot_history;
	logic [15:0] exp_q [$];
	logic [27:0] start;
	int          n_fail = 0;
	int          tests_run = 0;
	int          n_rst = 0;
	always #25 clk = ~clk;
	wrb_top DUT (.clk, .rst_b, .config_mode, .icp_valid, .icp_data, .icp_desync(1'b0), .bs_valid, .bs_data,
		.load_done, .err_bgchk(err_v[4]), .err_wrap(err_v[3]), .err_chk(err_v[2]), .err_id(err_v[1]),
		.err_wdog(err_v[0]), .init_status, .done_pin, .config_reset, .mem_clear(), .load_start,
		.revision_select_pins, .revision_select_oe, .flash_addr, .flash_addr_oe, .spi_mosi, .spi_cs_b,
		.config_halted, .boot_history);
	wrb_flash_model u_flash (.clk, .load_start, .err_sel, .emb, .spi_mosi, .spi_cs_b, .bs_valid, .bs_data,
		.load_done, .err_v, .spi_addr);
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// bounded wait; returns at a falling edge with the signal high
	task automatic wait_for(ref logic s);
		int i;
		for (i = 0; i < 400; i++) begin
			@(negedge clk);
			if (s === 1'b1)
				break;
		end
		if (i == 400) begin
			n_fail++;
			end_sim;
		end
	endtask
	// sync, start write, restart command, back to back
	task icp_restart(input logic [27:0] s);
		logic [31:0] w [5];
		w = '{wrb_pkg::SYNC_WORD, wrb_pkg::HDR_WR_START, {4'h0, s}, wrb_pkg::HDR_WR_CMD, wrb_pkg::CMD_RESTART};
		for (int i = 0; i < 5; i++) begin
			@(negedge clk);
			icp_valid = 1'b1;
			icp_data = w[i];
		end
		@(negedge clk);
		icp_valid = 1'b0;
		icp_data = ~icp_data;
	endtask
	always @(posedge clk) if (config_reset === 1'b1) n_rst++;
	// watcher: each load outcome takes the oldest expected history
	initial forever begin
		@(posedge clk);
		if ((load_done | (|err_v)) === 1'b1) begin
			repeat (2) @(negedge clk);
			chk("boot_history", 32'(exp_q.pop_front()), 32'(boot_history));
		end
	end
	initial begin
		void'($urandom(35));
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		exp_q.push_back(16'h0001);
		wait_for(load_start);
		chk("rs_oe", 32'h0, 32'(revision_select_oe));
		wait_for(done_pin);
		$display("first load test done");
		start = 28'($urandom);
		exp_q.push_back(16'h0105);
		icp_restart(start);
		wait_for(load_start);
		chk("rs", 32'(start[27:26]), 32'(revision_select_pins));
		chk("rs_oe", 32'h1, 32'(revision_select_oe));
		chk("addr", 32'(start[25:0]), 32'(flash_addr));
		chk("addr_oe", 32'h1, 32'(flash_addr_oe));
		wait_for(done_pin);
		chk("addr_oe", 32'h0, 32'(flash_addr_oe));
		chk("resets", 32'h1, 32'(n_rst));
		$display("port restart test done");
		// failing image, then a fallback image holding a restart word
		config_mode = 2'h2;
		err_sel = 5'h04;
		exp_q.push_back(16'h0525);
		exp_q.push_back(16'h2507);
		icp_restart(28'($urandom));
		wait_for(load_start);
		wait_for(config_reset);
		err_sel = 5'h00;
		emb = 1'b1;
		wait_for(load_start);
		chk("rs", 32'(wrb_pkg::RS_FALLBACK), 32'(revision_select_pins));
		chk("addr", 32'(wrb_pkg::ADDR_DOWN_DFLT), 32'(flash_addr));
		wait_for(done_pin);
		repeat (40) @(negedge clk);
		chk("resets", 32'h3, 32'(n_rst));
		$display("fallback test done");
		// serial flash: start field goes out on the serial line
		config_mode = 2'h3;
		emb = 1'b0;
		start = 28'($urandom);
		exp_q.push_back(16'h0705);
		icp_restart(start);
		wait_for(load_start);
		chk("rs", 32'(start[27:26]), 32'(revision_select_pins));
		chk("addr_oe", 32'h0, 32'(flash_addr_oe));
		wait_for(done_pin);
		chk("spi_addr", 32'(start[23:0]), 32'(spi_addr));
		chk("cs_b", 32'h1, 32'(spi_cs_b));
		$display("serial restart test done");
		// failing restart, fallback from zero fails again and halts
		err_sel = 5'h04;
		exp_q.push_back(16'h0525);
		exp_q.push_back(16'h2523);
		icp_restart(28'($urandom) | 28'h0000001);
		wait_for(config_halted);
		repeat (4) @(negedge clk);
		chk("spi_addr", 32'h0, 32'(spi_addr));
		chk("init", 32'h0, 32'(init_status));
		chk("resets", 32'h6, 32'(n_rst));
		chk("pending", 32'h0, 32'(exp_q.size()));
		$display("halt test done");
		end_sim;
	end
endmodule
